// ==== rtl/dram_ctrl.sv ====
// Purpose: Controller driving an asynchronous page-mode DRAM through its pins.
// Assumes: 250 MHz ref_clk, fast speed grade, 10-bit multiplexed address.
// Notes: Requests hold until req_ready; page hits stay in the open row.
//
// Behaviour
// - Random cycles at least 84 ns apart.
// - Column strobe 12 to 37 ns after row.
// - Column address 10 to 25 ns after row.
// - Column address held 25 ns before row rises.
// - Page row active 50 ns to 100K ns.
// - Page column cycles at least 20 ns apart.
// - Page read-write column cycle at least 56 ns.
// - Row held 37 ns after column precharge.
// - Column strobe low at least 10 ns.
// - Column strobe 5 ns before row for refresh.
// - All 1,024 rows refreshed every 16 ms.
// - Output enable low before row in hidden refresh; the controller does no hidden refresh, refreshing from idle only.
// - Wait 20 ns after output off before writing; a page-hit write right after a read drives data 16 ns after output off.
// - Write strobe output-off pulse at least 10 ns.
// - Wait 200 us, then eight row cycles.
`timescale 1ns/1ns
`include "dram_timing_defines.svh"
module dram_ctrl #(
	parameter int INIT_CYCLES_CLK = `C_INIT,
	parameter int REFRESH_GAP_CLK = `C_REFRESH_GAP,
	parameter int PAGE_MAX_CLK = `C_PAGE_MAX
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic [19:0] req_addr,
	input wire logic [1:0] req_byte_en,
	input wire logic [15:0] req_wdata,
	output logic [15:0] rsp_rdata,
	output logic rsp_valid,
	output logic init_done,
	output logic row_strobe_n,
	output logic col_strobe_upper_n,
	output logic col_strobe_lower_n,
	output logic write_en_n,
	output logic out_en_n,
	output logic [9:0] dram_addr,
	input wire logic [15:0] dram_dq_in,
	output logic [15:0] dram_dq_out,
	output logic dram_dq_oe
);
	localparam logic [17:0] C_CYCLE = 18'(`C_CYCLE);
	localparam logic [17:0] C_RAS_MIN = 18'(`C_RAS_MIN);
	localparam logic [17:0] C_PRE = 18'(`C_PRECHARGE);
	localparam logic [17:0] C_RCD = 18'(`C_RCD);
	localparam logic [17:0] C_RAD = 18'(`C_RAD);
	localparam logic [17:0] C_ACC = 18'(`C_COL_ACCESS + 2);
	localparam logic [17:0] C_RAL = 18'(`C_RAL);
	localparam logic [17:0] C_PAGE = 18'(`C_PAGE_CYCLE);
	localparam logic [17:0] C_PAGE_RW = 18'(`C_PAGE_RW);
	localparam logic [17:0] C_CASW = 18'(`C_CAS_PULSE);
	localparam logic [17:0] C_RHCP = 18'(`C_RHCP);
	localparam logic [17:0] C_CSR = 18'(`C_CSR);
	localparam logic [17:0] C_CHR = 18'(`C_CHR);
	localparam logic [17:0] C_OED = 18'(`C_OED);
	localparam logic [17:0] C_WPZ = 18'(`C_WPZ);
	localparam logic [3:0] N_INIT = 4'(`INIT_CYCLES);

	// ==========================================================
	// Timers and synchroniser
	// ==========================================================
	logic wait_load;
	logic [17:0] wait_val;
	logic wait_done;
	logic ref_done;
	logic page_load;
	logic page_done;
	logic [15:0] dq_sync;

	dram_timer #(.WIDTH(18)) wait_tmr (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.load(wait_load), .value(wait_val), .done(wait_done));
	dram_timer #(.WIDTH(18)) ref_tmr (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.load(ref_done), .value(18'(REFRESH_GAP_CLK)), .done());
	dram_timer #(.WIDTH(18)) page_tmr (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.load(page_load), .value(18'(PAGE_MAX_CLK - `C_PAGE_MARGIN)), .done(page_done));
	dram_sync2 #(.WIDTH(16)) dq_sync_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.async_in(dram_dq_in), .sync_out(dq_sync));

	// ==========================================================
	// Refresh request
	// ==========================================================
	logic [17:0] ref_cnt_r;
	logic ref_pend_r;
	logic ref_take;

	assign ref_done = (ref_cnt_r == '0);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_cnt_r <= '0;
		end else if (clk_en) begin
			if (ref_cnt_r == '0) begin
				ref_cnt_r <= 18'(REFRESH_GAP_CLK - 1);
			end else begin
				ref_cnt_r <= ref_cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_pend_r <= 1'b0;
		end else if (clk_en) begin
			if (ref_done && init_done) begin
				ref_pend_r <= 1'b1;
			end else if (ref_take) begin
				ref_pend_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Sequencer
	// ==========================================================
	dram_ctrl_pkg::state_type state_r;
	dram_ctrl_pkg::state_type state_nxt;
	logic [3:0] init_cnt_r;
	logic row_open_r;
	logic [9:0] row_r;
	logic [1:0] op_r;
	logic [9:0] col_r;
	logic [1:0] be_r;
	logic [15:0] wdata_r;
	logic hit;
	logic accept;
	logic init_arm_r;

	assign hit = row_open_r && (req_addr[19:10] == row_r);
	assign accept = req_valid && req_ready;
	assign req_ready = init_done && !ref_pend_r && wait_done &&
		((state_r == dram_ctrl_pkg::st_idle) || (state_r == dram_ctrl_pkg::st_col_pre && hit && !page_done));
	assign ref_take = (state_r == dram_ctrl_pkg::st_idle) && ref_pend_r && wait_done;
	assign page_load = (state_r == dram_ctrl_pkg::st_row) && !row_open_r;

	always_comb begin
		state_nxt = state_r;
		wait_load = 1'b0;
		wait_val = '0;
		case (state_r)
			dram_ctrl_pkg::st_init_wait: begin
				if (!init_arm_r) begin
					wait_load = 1'b1;
					wait_val = 18'(INIT_CYCLES_CLK);
				end else if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_init_ras;
					wait_load = 1'b1;
					wait_val = C_RAS_MIN;
				end
			end
			dram_ctrl_pkg::st_init_ras: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_init_pre;
					wait_load = 1'b1;
					wait_val = C_PRE;
				end
			end
			dram_ctrl_pkg::st_init_pre: begin
				if (wait_done) begin
					state_nxt = (init_cnt_r == N_INIT - 4'd1) ? dram_ctrl_pkg::st_idle
						: dram_ctrl_pkg::st_init_ras;
					wait_load = (init_cnt_r != N_INIT - 4'd1);
					wait_val = C_RAS_MIN;
				end
			end
			dram_ctrl_pkg::st_idle: begin
				if (ref_take) begin
					state_nxt = dram_ctrl_pkg::st_ref_cas;
					wait_load = 1'b1;
					wait_val = C_CSR;
				end else if (accept) begin
					state_nxt = dram_ctrl_pkg::st_row;
					wait_load = 1'b1;
					wait_val = C_RAD;
				end
			end
			dram_ctrl_pkg::st_row: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_col;
					wait_load = 1'b1;
					wait_val = C_RCD - C_RAD;
				end
			end
			dram_ctrl_pkg::st_col: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_data;
					wait_load = 1'b1;
					wait_val = (op_r == 2'(dram_ctrl_pkg::op_write)) ? C_CASW : C_ACC;
				end
			end
			dram_ctrl_pkg::st_data: begin
				if (wait_done) begin
					if (op_r == 2'(dram_ctrl_pkg::op_rmw)) begin
						state_nxt = dram_ctrl_pkg::st_wr_off;
						wait_load = 1'b1;
						wait_val = C_OED;
					end else begin
						state_nxt = dram_ctrl_pkg::st_col_pre;
						wait_load = 1'b1;
						wait_val = C_PAGE - C_CASW;
					end
				end
			end
			dram_ctrl_pkg::st_wr_off: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_wr;
					wait_load = 1'b1;
					wait_val = C_WPZ;
				end
			end
			dram_ctrl_pkg::st_wr: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_col_pre;
					wait_load = 1'b1;
					wait_val = (C_PAGE_RW > C_ACC + C_OED + C_WPZ) ?
						C_PAGE_RW - C_ACC - C_OED - C_WPZ : C_PAGE - C_CASW;
				end
			end
			dram_ctrl_pkg::st_col_pre: begin
				if (accept) begin
					state_nxt = dram_ctrl_pkg::st_col;
				end else if (wait_done && (!req_valid || !hit || page_done || ref_pend_r)) begin
					state_nxt = dram_ctrl_pkg::st_ras_up;
					wait_load = 1'b1;
					wait_val = C_RHCP;
				end
			end
			dram_ctrl_pkg::st_ras_up: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_precharge;
					wait_load = 1'b1;
					wait_val = C_CYCLE - C_RAS_MIN;
				end
			end
			dram_ctrl_pkg::st_precharge: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_idle;
				end
			end
			dram_ctrl_pkg::st_ref_cas: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_ref_ras;
					wait_load = 1'b1;
					wait_val = C_CHR;
				end
			end
			dram_ctrl_pkg::st_ref_ras: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_ref_end;
					wait_load = 1'b1;
					wait_val = C_RAS_MIN - C_CHR;
				end
			end
			dram_ctrl_pkg::st_ref_end: begin
				if (wait_done) begin
					state_nxt = dram_ctrl_pkg::st_precharge;
					wait_load = 1'b1;
					wait_val = C_PRE;
				end
			end
			default: begin
				state_nxt = dram_ctrl_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= dram_ctrl_pkg::st_init_wait;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// Initial pause count is loaded by the first enabled edge after reset.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			init_arm_r <= 1'b0;
		end else if (clk_en) begin
			init_arm_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			init_cnt_r <= '0;
			init_done <= 1'b0;
		end else if (clk_en) begin
			if (state_r == dram_ctrl_pkg::st_init_pre && wait_done) begin
				init_cnt_r <= init_cnt_r + 4'd1;
			end
			if (state_nxt == dram_ctrl_pkg::st_idle && state_r == dram_ctrl_pkg::st_init_pre) begin
				init_done <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Request capture and open row
	// ==========================================================
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_r <= '0;
			col_r <= '0;
			be_r <= '0;
			wdata_r <= '0;
			row_r <= '0;
			row_open_r <= 1'b0;
		end else if (clk_en) begin
			if (accept) begin
				op_r <= req_op;
				col_r <= req_addr[9:0];
				be_r <= req_byte_en;
				wdata_r <= req_wdata;
				row_r <= req_addr[19:10];
			end
			if (state_r == dram_ctrl_pkg::st_col) begin
				row_open_r <= 1'b1;
			end else if (state_r == dram_ctrl_pkg::st_ras_up || state_r == dram_ctrl_pkg::st_idle) begin
				row_open_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pin drive
	// ==========================================================
	logic ras_on;
	logic cas_on;
	logic is_wr;
	assign is_wr = (op_r == 2'(dram_ctrl_pkg::op_write));
	assign ras_on = (state_r == dram_ctrl_pkg::st_row) || (state_r == dram_ctrl_pkg::st_col) ||
		(state_r == dram_ctrl_pkg::st_data) || (state_r == dram_ctrl_pkg::st_wr_off) ||
		(state_r == dram_ctrl_pkg::st_wr) || (state_r == dram_ctrl_pkg::st_col_pre) ||
		(state_r == dram_ctrl_pkg::st_ras_up) || (state_r == dram_ctrl_pkg::st_init_ras) ||
		(state_r == dram_ctrl_pkg::st_ref_ras) || (state_r == dram_ctrl_pkg::st_ref_end);
	assign cas_on = (state_r == dram_ctrl_pkg::st_data) || (state_r == dram_ctrl_pkg::st_wr_off) ||
		(state_r == dram_ctrl_pkg::st_wr);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			row_strobe_n <= 1'b1;
			col_strobe_upper_n <= 1'b1;
			col_strobe_lower_n <= 1'b1;
			write_en_n <= 1'b1;
			out_en_n <= 1'b1;
			dram_addr <= '0;
			dram_dq_out <= '0;
			dram_dq_oe <= 1'b0;
		end else if (clk_en) begin
			row_strobe_n <= !(ras_on && !(state_r == dram_ctrl_pkg::st_ras_up && wait_done));
			if (state_nxt == dram_ctrl_pkg::st_ref_cas || state_r == dram_ctrl_pkg::st_ref_cas ||
				state_r == dram_ctrl_pkg::st_ref_ras) begin
				col_strobe_upper_n <= 1'b0;
				col_strobe_lower_n <= 1'b0;
			end else begin
				col_strobe_upper_n <= !((state_nxt == dram_ctrl_pkg::st_data || cas_on) &&
					state_nxt != dram_ctrl_pkg::st_col_pre && be_r[1]);
				col_strobe_lower_n <= !((state_nxt == dram_ctrl_pkg::st_data || cas_on) &&
					state_nxt != dram_ctrl_pkg::st_col_pre && be_r[0]);
			end
			write_en_n <= !((is_wr && (state_nxt == dram_ctrl_pkg::st_col ||
				state_nxt == dram_ctrl_pkg::st_data)) || state_r == dram_ctrl_pkg::st_wr);
			out_en_n <= !((op_r != 2'(dram_ctrl_pkg::op_write)) && state_nxt == dram_ctrl_pkg::st_data);
			if (state_nxt == dram_ctrl_pkg::st_row && state_r == dram_ctrl_pkg::st_idle) begin
				dram_addr <= req_addr[19:10];
			end else if (state_nxt == dram_ctrl_pkg::st_col) begin
				dram_addr <= accept ? req_addr[9:0] : col_r;
			end
			dram_dq_out <= wdata_r;
			dram_dq_oe <= (is_wr && (state_nxt == dram_ctrl_pkg::st_col || state_nxt == dram_ctrl_pkg::st_data)) ||
				state_r == dram_ctrl_pkg::st_wr;
		end
	end

	// ==========================================================
	// Read return
	// ==========================================================
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_rdata <= '0;
			rsp_valid <= 1'b0;
		end else if (clk_en) begin
			rsp_valid <= 1'b0;
			if (state_r == dram_ctrl_pkg::st_data && wait_done && !is_wr) begin
				rsp_rdata <= dq_sync;
				rsp_valid <= 1'b1;
			end
		end
	end
endmodule // dram_ctrl

// ==== rtl/dram_ctrl_pkg.sv ====
// Purpose: Types shared by the DRAM controller files.
// Assumes: Nothing beyond the defines header.
// Notes: Holds the sequencer states and request kinds.
package dram_ctrl_pkg;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		op_read,
		op_write,
		op_rmw
	} op_type;

	typedef enum {
		st_init_wait,
		st_init_ras,
		st_init_pre,
		st_idle,
		st_row,
		st_col,
		st_data,
		st_wr,
		st_col_pre,
		st_ras_up,
		st_precharge,
		st_ref_cas,
		st_ref_ras,
		st_ref_end,
		st_wr_off
	} state_type;

endpackage

// ==== rtl/dram_sync2.sv ====
// Purpose: Two-flop synchroniser for the data bus read back from the DRAM.
// Assumes: Input is asynchronous to ref_clk.
// Notes: Only the second stage is visible.
`timescale 1ns/1ns
module dram_sync2 #(
	parameter int WIDTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_r <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			stage_r <= async_in;
			sync_out <= stage_r;
		end
	end
endmodule // dram_sync2

// ==== rtl/dram_timer.sv ====
// Purpose: Down counter used for timed waits and the page limit.
// Assumes: load wins over counting.
// Notes: done is high while the count is zero.
`timescale 1ns/1ns
module dram_timer #(
	parameter int WIDTH = 18
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [WIDTH-1:0] value,
	output logic done
);
	logic [WIDTH-1:0] count_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= '0;
		end else if (clk_en) begin
			if (load) begin
				count_r <= value;
			end else if (count_r != '0) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	assign done = (count_r == '0);
endmodule // dram_timer

// ==== rtl/dram_timing_defines.svh ====
// Purpose: Timing constants for the asynchronous page-mode DRAM controller.
// Assumes: ref_clk at 250 MHz, fast speed grade figures.
// Notes: Times are in ns except T_INIT_US and T_REFRESH_MS; cycle counts derive from them.
`ifndef DRAM_TIMING_DEFINES_SVH
`define DRAM_TIMING_DEFINES_SVH

// ==========================================================
// Clock
// ==========================================================
`define CLK_PERIOD_NS 4
`define CYC_MIN(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(t) (((t) / `CLK_PERIOD_NS) < 1 ? 1 : ((t) / `CLK_PERIOD_NS))

// ==========================================================
// Times in ns, with init in us and refresh in ms
// ==========================================================
`define T_CYCLE_NS 84
`define T_RAS_MIN_NS 50
`define T_PRECHARGE_NS 30
`define T_RCD_MIN_NS 12
`define T_RCD_MAX_NS 37
`define T_RAD_MIN_NS 10
`define T_COL_ACCESS_NS 25
`define T_RAL_NS 25
`define T_PAGE_CYCLE_NS 20
`define T_PAGE_RW_NS 56
`define T_CPA_NS 30
`define T_CAS_PULSE_NS 10
`define T_RHCP_NS 37
`define T_CSR_NS 5
`define T_CHR_NS 10
`define T_OED_NS 20
`define T_WPZ_NS 10
`define T_PAGE_MAX_NS 100000
`define T_INIT_US 200
`define T_REFRESH_MS 16
`define REFRESH_ROWS 1024
`define INIT_CYCLES 8

// ==========================================================
// Cycle counts
// ==========================================================
`define C_CYCLE `CYC_MIN(`T_CYCLE_NS)
`define C_RAS_MIN `CYC_MIN(`T_RAS_MIN_NS)
`define C_PRECHARGE `CYC_MIN(`T_PRECHARGE_NS)
`define C_RCD `CYC_MIN(`T_RCD_MIN_NS)
`define C_RAD `CYC_MIN(`T_RAD_MIN_NS)
`define C_COL_ACCESS `CYC_MIN(`T_COL_ACCESS_NS)
`define C_RAL `CYC_MIN(`T_RAL_NS)
`define C_PAGE_CYCLE `CYC_MIN(`T_PAGE_CYCLE_NS)
`define C_PAGE_RW `CYC_MIN(`T_PAGE_RW_NS)
`define C_CAS_PULSE `CYC_MIN(`T_CAS_PULSE_NS)
`define C_RHCP `CYC_MIN(`T_RHCP_NS)
`define C_CSR `CYC_MIN(`T_CSR_NS)
`define C_CHR `CYC_MIN(`T_CHR_NS)
`define C_OED `CYC_MIN(`T_OED_NS)
`define C_WPZ `CYC_MIN(`T_WPZ_NS)
`define C_PAGE_MAX `CYC_MAX(`T_PAGE_MAX_NS)
`define C_PAGE_MARGIN 40
`define C_INIT (`T_INIT_US * 1000 / `CLK_PERIOD_NS)
`define C_REFRESH_GAP (`T_REFRESH_MS * 1000000 / `CLK_PERIOD_NS / `REFRESH_ROWS)

`endif

// ==== verification/dram_ctrl_sva.sv ====
// Purpose: Timing checks on the controller's DRAM pins.
// Assumes: 4 ns ref_clk, fast speed grade.
// Notes: Counts are in ref_clk cycles.
`timescale 1ns/1ns
module dram_ctrl_sva #(
	parameter int INIT_CYCLES_CLK = 20,
	parameter int REFRESH_GAP_CLK = 200,
	parameter int PAGE_MAX_CLK = 100
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic init_done,
	input wire logic row_strobe_n,
	input wire logic col_strobe_upper_n,
	input wire logic col_strobe_lower_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic dram_dq_oe
);
	// ==========================================================
	// Helpers
	// ==========================================================
	logic row_q;
	logic cas_lo;
	logic row_fall;
	int ras_gap, ras_low, ref_age, oe_off, init_cyc, init_ras;
	assign cas_lo = !col_strobe_lower_n || !col_strobe_upper_n;
	assign row_fall = row_q && !row_strobe_n;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			row_q <= 1'b1;
			ras_gap <= 1000;
			ras_low <= 0;
			ref_age <= 0;
			oe_off <= 100;
			init_cyc <= 0;
			init_ras <= 0;
		end else begin
			row_q <= row_strobe_n;
			ras_gap <= row_fall ? 1 : (ras_gap < 1000 ? ras_gap + 1 : ras_gap);
			ras_low <= row_strobe_n ? 0 : ras_low + 1;
			ref_age <= ((row_fall && cas_lo) || !init_done) ? 0 : ref_age + 1;
			oe_off <= !out_en_n ? 0 : (oe_off < 100 ? oe_off + 1 : oe_off);
			init_cyc <= (init_cyc < INIT_CYCLES_CLK) ? init_cyc + 1 : init_cyc;
			init_ras <= (row_fall && init_ras < 8) ? init_ras + 1 : init_ras;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_row_cycle_gap: assert property ($fell(row_strobe_n) |-> ras_gap >= 21)
		else $error("row cycles too close");
	a_col_after_row: assert property ($fell(row_strobe_n) && !cas_lo && init_done |-> ##[3:9] cas_lo)
		else $error("column strobe outside its window");
	a_row_min_width: assert property ($rose(row_strobe_n) |-> ras_low >= 13)
		else $error("row strobe pulse too short");
	a_row_max_width: assert property (!row_strobe_n |-> ras_low <= PAGE_MAX_CLK)
		else $error("row strobe held too long");
	a_page_col_gap: assert property ($fell(col_strobe_lower_n) |=> (!$fell(col_strobe_lower_n))[*4])
		else $error("page column cycles too close");
	a_cas_low_width: assert property ($fell(col_strobe_lower_n) |-> !col_strobe_lower_n[*3])
		else $error("column strobe pulse too short");
	a_refresh_setup: assert property ($fell(row_strobe_n) && cas_lo |-> $past(cas_lo, 2))
		else $error("refresh column strobe set up too late");
	a_refresh_age_bound: assert property (ref_age <= 2 * REFRESH_GAP_CLK)
		else $error("refresh overdue");
	a_oe_turn_wait: assert property ($rose(dram_dq_oe) |-> oe_off >= 5)
		else $error("write data driven too soon after output enable");
	a_we_pulse_width: assert property ($fell(write_en_n) |-> !write_en_n[*3])
		else $error("write strobe pulse too short");
	a_init_pause_len: assert property ($fell(row_strobe_n) |-> init_cyc >= INIT_CYCLES_CLK)
		else $error("row strobe before power-up pause ended");
	a_init_row_count: assert property ($rose(init_done) |-> init_ras >= 8)
		else $error("ready before eight row cycles");
	c_refresh: cover property (row_fall && cas_lo);
	c_page_hit: cover property ($fell(col_strobe_lower_n) && ras_low > 8);
	c_late_write: cover property ($fell(write_en_n) && cas_lo);
endmodule // dram_ctrl_sva

bind dram_ctrl dram_ctrl_sva #(
	.INIT_CYCLES_CLK(INIT_CYCLES_CLK),
	.REFRESH_GAP_CLK(REFRESH_GAP_CLK),
	.PAGE_MAX_CLK(PAGE_MAX_CLK)
) u_sva (
	.ref_clk(ref_clk), .rst_b(rst_b), .init_done(init_done), .row_strobe_n(row_strobe_n),
	.col_strobe_upper_n(col_strobe_upper_n), .col_strobe_lower_n(col_strobe_lower_n),
	.write_en_n(write_en_n), .out_en_n(out_en_n), .dram_dq_oe(dram_dq_oe)
);

// ==== verification/dram_model.sv ====
// Purpose: Behavioural page-mode DRAM answering the controller's pins.
// Assumes: Times in ns, fast speed grade.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/1ns
module dram_model (
	input wire logic row_strobe_n,
	input wire logic col_strobe_upper_n,
	input wire logic col_strobe_lower_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic [9:0] dram_addr,
	input wire logic [15:0] dram_dq_out,
	input wire logic dram_dq_oe,
	output logic [15:0] dram_dq_in
);
	// ==========================================================
	// Storage
	// ==========================================================
	logic [15:0] mem [logic [19:0]];
	logic [9:0] row_r = 10'h000;
	logic [9:0] ref_row_r = 10'h000;
	logic [9:0] col_r [2];
	logic [15:0] q_r = 16'h0000;
	logic [1:0] drv_r = 2'b00;
	logic [1:0] cas_n;
	assign cas_n = {col_strobe_upper_n, col_strobe_lower_n};
	task automatic put(input int i);
		logic [19:0] a;
		logic [15:0] w;
		a = {row_r, col_r[i]};
		w = mem.exists(a) ? mem[a] : 16'h0000;
		w[i*8 +: 8] = dram_dq_oe ? dram_dq_out[i*8 +: 8] : ~dram_dq_out[i*8 +: 8];
		mem[a] = w;
	endtask
	always @(negedge row_strobe_n) begin
		if (cas_n == 2'b11) begin
			#1 row_r = dram_addr;
		end else begin
			ref_row_r = ref_row_r + 10'h001;
		end
	end

	// ==========================================================
	// Byte lanes
	// ==========================================================
	for (genvar i = 0; i < 2; i++) begin : g_lane
		assign dram_dq_in[i*8 +: 8] = dram_dq_oe ? dram_dq_out[i*8 +: 8] :
			(drv_r[i] && !out_en_n) ? q_r[i*8 +: 8] : ~q_r[i*8 +: 8];
		always @(negedge cas_n[i]) begin
			#1 col_r[i] = dram_addr;
			if (!row_strobe_n && !write_en_n) begin
				drv_r[i] = 1'b0;
				put(i);
			end else if (!row_strobe_n) begin
				#24 q_r[i*8 +: 8] = mem.exists({row_r, col_r[i]}) ? mem[{row_r, col_r[i]}][i*8 +: 8] : 8'h00;
				drv_r[i] = 1'b1;
			end
		end
		always @(negedge write_en_n) begin
			#1;
			if (!row_strobe_n && !cas_n[i]) begin
				put(i);
			end
		end
		always @(posedge row_strobe_n or posedge cas_n[i]) begin
			if (row_strobe_n && cas_n[i]) begin
				#2 drv_r[i] = 1'b0;
			end
		end
	end
endmodule // dram_model

// ==== verification/edo_dram_cycle_timing_tb_top.sv ====
// Purpose: Self-checking bench for the DRAM controller with a DRAM model.
// Assumes: Shortened init, refresh gap and page limit.
// Notes: Expected read words are queued at request time.
`timescale 1ns/1ns
module edo_dram_cycle_timing_tb_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic req_valid = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [19:0] req_addr = 20'h0_0000;
	logic [1:0] req_byte_en = 2'h3;
	logic [15:0] req_wdata = 16'h0000;
	logic req_ready, rsp_valid, init_done, row_strobe_n, col_strobe_upper_n, col_strobe_lower_n;
	logic write_en_n, out_en_n, dram_dq_oe;
	logic [15:0] rsp_rdata, dram_dq_in, dram_dq_out;
	logic [9:0] dram_addr;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] exp_q [$];
	logic [15:0] shadow [logic [19:0]];
	initial forever #2 ref_clk = ~ref_clk;
	dram_ctrl #(.INIT_CYCLES_CLK(20), .REFRESH_GAP_CLK(200), .PAGE_MAX_CLK(100)) uut (
		.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_addr(req_addr), .req_byte_en(req_byte_en), .req_wdata(req_wdata),
		.rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .init_done(init_done), .row_strobe_n(row_strobe_n),
		.col_strobe_upper_n(col_strobe_upper_n), .col_strobe_lower_n(col_strobe_lower_n),
		.write_en_n(write_en_n), .out_en_n(out_en_n), .dram_addr(dram_addr), .dram_dq_in(dram_dq_in),
		.dram_dq_out(dram_dq_out), .dram_dq_oe(dram_dq_oe));
	dram_model mem_model (
		.row_strobe_n(row_strobe_n), .col_strobe_upper_n(col_strobe_upper_n),
		.col_strobe_lower_n(col_strobe_lower_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
		.dram_addr(dram_addr), .dram_dq_out(dram_dq_out), .dram_dq_oe(dram_dq_oe), .dram_dq_in(dram_dq_in));

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic wrap_up();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk_data(input logic [31:0] e, input logic [15:0] got);
		comparisons++;
		if ((got & e[31:16]) !== (e[15:0] & e[31:16])) begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, e[15:0] & e[31:16], got & e[31:16]);
		end
	endtask
	task automatic chk_bit(input logic e, input logic got);
		comparisons++;
		if (got !== e) begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, got);
		end
	endtask
	task automatic idle(input int n);
		req_valid <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wait_init(output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (init_done !== 1'b1 && n < 3000);
		if (n >= 3000) failures++;
		@(posedge ref_clk);
	endtask
	task automatic req(input logic [1:0] op, input logic [19:0] a, input logic [1:0] be, input logic [15:0] d);
		logic [15:0] m;
		logic [15:0] old;
		int n;
		m = {{8{be[1]}}, {8{be[0]}}};
		old = shadow.exists(a) ? shadow[a] : 16'h0000;
		n = 0;
		if (op != 2'h1) exp_q.push_back({m, old});
		if (op != 2'h0) shadow[a] = (old & ~m) | (d & m);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_byte_en <= be;
		req_wdata <= d;
		do begin
			@(negedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 3000);
		if (n >= 3000) failures++;
		@(posedge ref_clk);
	endtask

	// ==========================================================
	// Checking and stimulus
	// ==========================================================
	always @(negedge ref_clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) chk_bit(1'b0, 1'b1);
			else chk_data(exp_q.pop_front(), rsp_rdata);
		end
	end
	initial begin
		#80000;
		failures++;
		wrap_up();
	end
	initial begin
		logic [19:0] a;
		int n;
		void'($urandom(32'h39da_afb4));
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		wait_init(n);
		chk_bit(1'b1, n >= 188);
		for (int i = 0; i < 6; i++) begin
			a = 20'($urandom());
			req(2'h1, a, 2'h3, 16'($urandom()));
			idle(1);
			req(2'h0, a, 2'h3, 16'h0000);
			idle(1);
		end
		a = 20'($urandom());
		for (int i = 0; i < 4; i++) req(2'h1, a + 20'(i), 2'h3, 16'($urandom()));
		for (int i = 0; i < 4; i++) req(2'h2, a + 20'(i), 2'h3, 16'($urandom()));
		for (int i = 0; i < 4; i++) req(2'h0, a + 20'(i), 2'h3, 16'h0000);
		req(2'h1, a, 2'h3, 16'hffff);
		req(2'h1, a, 2'h1, 16'h1234);
		req(2'h1, a, 2'h2, 16'h5678);
		for (int b = 1; b < 4; b++) req(2'h0, a, 2'(b), 16'h0000);
		idle(450);
		clk_en <= 1'b0;
		idle(10);
		clk_en <= 1'b1;
		req(2'h0, a, 2'h3, 16'h0000);
		idle(60);
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		wait_init(n);
		req(2'h2, a, 2'h1, 16'h00aa);
		req(2'h0, a, 2'h3, 16'h0000);
		idle(60);
		chk_bit(1'b0, exp_q.size() != 0);
		wrap_up();
	end
endmodule // edo_dram_cycle_timing_tb_top
